// [rtl/cic_pkg.sv]
// Summary of operation
// - An 8-bit control register holds global enable (bit 7), peripheral enable (bit 6), timer enable (bit 5) and timer flag (bit 2), all readable and writable.
// - The control register answers at index 0Bh and at its mirror 8Bh with one storage, and reset clears every bit.
// - A timer overflow sets the timer flag whatever the enable bits hold.
// - The timer flag stays set until software writes a zero to it; hardware never clears it.
// - The timer flag can request an interrupt only while the timer enable is one.
// - The peripheral pending input passes only while the peripheral enable is one.
// - No request reaches the core while the global enable is zero.
`default_nettype none
package cic_pkg;

    // =========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] CIC_IDX_CTRL = 10'h00b;
    localparam logic [9:0] CIC_IDX_CTRL_MIRROR = 10'h08b;
    localparam logic [9:0] CIC_IDX_IRQ_STATUS = 10'h010;
    localparam logic [9:0] CIC_IDX_IRQ_CLEAR = 10'h011;
    localparam logic [9:0] CIC_IDX_IRQ_ENABLE = 10'h012;

    // =========================================================
    // Control register fields
    localparam int CIC_BIT_GLOBAL_EN = 7;
    localparam int CIC_BIT_PERIPH_EN = 6;
    localparam int CIC_BIT_TIMER_EN = 5;
    localparam int CIC_BIT_TIMER_FLAG = 2;
    localparam logic [7:0] CIC_CTRL_RESET = 8'h00;

    // =========================================================
    // Event status layout
    localparam int CIC_EVT_W = 2;
    localparam int CIC_EVT_TIMER = 0;
    localparam int CIC_EVT_PERIPH = 1;
    localparam logic [1:0] CIC_EVT_RESET = 2'h0;

    // =========================================================
    // Bus encodings
    localparam logic [1:0] CIC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CIC_HSIZE_WORD = 3'h2;
    localparam logic CIC_HRESP_OKAY = 1'b0;
    localparam logic [31:0] CIC_HRDATA_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        CIC_BUS_IDLE = 2'b01,
        CIC_BUS_RDWAIT = 2'b10
    } cic_bus_state_t;

    function automatic logic cicIsCtrl(input logic [9:0] idx);
        return (idx == CIC_IDX_CTRL) || (idx == CIC_IDX_CTRL_MIRROR);
    endfunction

endpackage
`default_nettype wire

// [rtl/cic_ahb_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_ahb_slave
    import cic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] readData,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic wrEn,
    output logic [9:0] accIndex
);

    // =========================================================
    // Address phase decode
    logic addrTake;
    logic addrOk;
    cic_bus_state_t busState;

    assign addrTake = hsel && hready && htrans == CIC_HTRANS_NONSEQ;
    assign addrOk = addrTake && hsize == CIC_HSIZE_WORD &&
        haddr[1:0] == 2'h0 && haddr[31:12] == 20'h00000;

    // =========================================================
    // Captured index and write strobe for the data phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            accIndex <= 10'h000;
            wrEn <= 1'b0;
        end
        else if (ce)
        begin
            if (addrTake)
            begin
                accIndex <= addrOk ? haddr[11:2] : 10'h3ff;
            end
            wrEn <= addrOk && hwrite;
        end
    end

    // =========================================================
    // Reads take one wait state so earlier writes are visible
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            busState <= CIC_BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= CIC_HRDATA_RESET;
        end
        else if (ce)
        begin
            unique case (busState)
                CIC_BUS_IDLE:
                begin
                    if (addrTake && !hwrite)
                    begin
                        busState <= CIC_BUS_RDWAIT;
                        hreadyout <= 1'b0;
                    end
                end
                CIC_BUS_RDWAIT:
                begin
                    busState <= CIC_BUS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata <= readData;
                end
                default:
                begin
                    busState <= CIC_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

endmodule // cic_ahb_slave
`default_nettype wire

// [rtl/cic_core_interrupt_control.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_core_interrupt_control
    import cic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timerOverflow,
    input wire logic periphPending,
    output logic coreIrqReq,
    output logic sysIrq
);

    // =========================================================
    // Bus slave
    logic busWrEn;
    logic [9:0] busIndex;
    logic [31:0] readData;

    cic_ahb_slave u_slave (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .readData(readData),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .wrEn(busWrEn),
        .accIndex(busIndex)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hresp <= CIC_HRESP_OKAY;
        end
        else if (ce)
        begin
            hresp <= CIC_HRESP_OKAY;
        end
    end

    // =========================================================
    // Write decode
    logic wrCtrl;
    logic wrClear;
    logic wrEnable;

    assign wrCtrl = busWrEn && cicIsCtrl(busIndex);
    assign wrClear = busWrEn && busIndex == CIC_IDX_IRQ_CLEAR;
    assign wrEnable = busWrEn && busIndex == CIC_IDX_IRQ_ENABLE;

    // =========================================================
    // Control register enable bits
    logic globalEnReg;
    logic periphEnReg;
    logic timerEnReg;
    logic timerFlagReg;
    logic timerFlagNext;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            globalEnReg <= CIC_CTRL_RESET[CIC_BIT_GLOBAL_EN];
            periphEnReg <= CIC_CTRL_RESET[CIC_BIT_PERIPH_EN];
            timerEnReg <= CIC_CTRL_RESET[CIC_BIT_TIMER_EN];
        end
        else if (ce && wrCtrl)
        begin
            globalEnReg <= hwdata[CIC_BIT_GLOBAL_EN];
            periphEnReg <= hwdata[CIC_BIT_PERIPH_EN];
            timerEnReg <= hwdata[CIC_BIT_TIMER_EN];
        end
    end

    // =========================================================
    // Timer flag: overflow wins over a software clear
    assign timerFlagNext = timerOverflow ||
        (wrCtrl ? hwdata[CIC_BIT_TIMER_FLAG] : timerFlagReg);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timerFlagReg <= CIC_CTRL_RESET[CIC_BIT_TIMER_FLAG];
        end
        else if (ce)
        begin
            timerFlagReg <= timerFlagNext;
        end
    end

    // =========================================================
    // Request toward the core
    logic timerReq;
    logic periphReq;
    logic coreIrqNext;

    assign timerReq = timerEnReg && timerFlagReg;
    assign periphReq = periphEnReg && periphPending;
    assign coreIrqNext = globalEnReg && (timerReq || periphReq);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            coreIrqReq <= 1'b0;
        end
        else if (ce)
        begin
            coreIrqReq <= coreIrqNext;
        end
    end

    // =========================================================
    // System event status, clear and enable
    logic [CIC_EVT_W-1:0] evtStatusReg;
    logic [CIC_EVT_W-1:0] evtEnableReg;
    logic [CIC_EVT_W-1:0] evtSet;
    logic [CIC_EVT_W-1:0] evtClr;
    logic periphReqPrev;

    always_comb
    begin
        evtSet = CIC_EVT_RESET;
        evtSet[CIC_EVT_TIMER] = timerOverflow;
        evtSet[CIC_EVT_PERIPH] = periphReq && !periphReqPrev;
        evtClr = wrClear ? hwdata[CIC_EVT_W-1:0] : CIC_EVT_RESET;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            periphReqPrev <= 1'b0;
        end
        else if (ce)
        begin
            periphReqPrev <= periphReq;
        end
    end

    // Set wins over clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            evtStatusReg <= CIC_EVT_RESET;
        end
        else if (ce)
        begin
            evtStatusReg <= evtSet | (evtStatusReg & ~evtClr);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            evtEnableReg <= CIC_EVT_RESET;
        end
        else if (ce && wrEnable)
        begin
            evtEnableReg <= hwdata[CIC_EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sysIrq <= 1'b0;
        end
        else if (ce)
        begin
            sysIrq <= |(evtStatusReg & evtEnableReg);
        end
    end

    // =========================================================
    // Read mux, reserved bits and unmapped words read zero
    logic [7:0] ctrlValue;

    always_comb
    begin
        ctrlValue = 8'h00;
        ctrlValue[CIC_BIT_GLOBAL_EN] = globalEnReg;
        ctrlValue[CIC_BIT_PERIPH_EN] = periphEnReg;
        ctrlValue[CIC_BIT_TIMER_EN] = timerEnReg;
        ctrlValue[CIC_BIT_TIMER_FLAG] = timerFlagReg;
        readData = 32'h00000000;
        if (cicIsCtrl(busIndex))
        begin
            readData = {24'h000000, ctrlValue};
        end
        else if (busIndex == CIC_IDX_IRQ_STATUS)
        begin
            readData = {30'h00000000, evtStatusReg};
        end
        else if (busIndex == CIC_IDX_IRQ_ENABLE)
        begin
            readData = {30'h00000000, evtEnableReg};
        end
    end

    // =========================================================
    // Assertions
    property p_ctrl_store;
        @(posedge mclk) disable iff (rst)
        (ce && wrCtrl) |=>
            globalEnReg == $past(hwdata[CIC_BIT_GLOBAL_EN]) &&
            periphEnReg == $past(hwdata[CIC_BIT_PERIPH_EN]) &&
            timerEnReg == $past(hwdata[CIC_BIT_TIMER_EN]);
    endproperty
    a_ctrl_store: assert property (p_ctrl_store)
        else $error("control write not stored");

    property p_ctrl_readback;
        @(posedge mclk) disable iff (rst)
        (ce && !hreadyout && cicIsCtrl(busIndex)) |=>
            hrdata[7:0] == {$past(globalEnReg), $past(periphEnReg),
            $past(timerEnReg), 2'b00, $past(timerFlagReg), 2'b00};
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control read at either index is wrong");

    property p_flag_set;
        @(posedge mclk) disable iff (rst)
        (ce && timerOverflow) |=> timerFlagReg;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("overflow did not set timer flag");

    property p_flag_hold;
        @(posedge mclk) disable iff (rst)
        (timerFlagReg && !(ce && wrCtrl && !hwdata[CIC_BIT_TIMER_FLAG]))
            |=> timerFlagReg;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("timer flag cleared without a software write");

    property p_timer_block;
        @(posedge mclk) disable iff (rst)
        (ce && !timerEnReg && !(periphEnReg && periphPending)) |=>
            !coreIrqReq;
    endproperty
    a_timer_block: assert property (p_timer_block)
        else $error("timer flag requested while timer disabled");

    property p_periph_block;
        @(posedge mclk) disable iff (rst)
        (ce && !periphEnReg && !(timerEnReg && timerFlagReg)) |=>
            !coreIrqReq;
    endproperty
    a_periph_block: assert property (p_periph_block)
        else $error("peripheral passed while peripheral disabled");

    property p_global_block;
        @(posedge mclk) disable iff (rst)
        (ce && !globalEnReg) |=> !coreIrqReq;
    endproperty
    a_global_block: assert property (p_global_block)
        else $error("request while global enable clear");

    property p_core_req;
        @(posedge mclk) disable iff (rst)
        ce |=> coreIrqReq == $past(globalEnReg && ((timerEnReg &&
            timerFlagReg) || (periphEnReg && periphPending)));
    endproperty
    a_core_req: assert property (p_core_req)
        else $error("core request does not follow enables and flags");

    property p_sys_irq;
        @(posedge mclk) disable iff (rst)
        ce |=> sysIrq == $past(|(evtStatusReg & evtEnableReg));
    endproperty
    a_sys_irq: assert property (p_sys_irq)
        else $error("system interrupt does not follow status and enable");

    property p_freeze;
        @(posedge mclk) disable iff (rst)
        !ce |=> $stable(coreIrqReq) && $stable(timerFlagReg) &&
            $stable(globalEnReg) && $stable(evtStatusReg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state changed while clock enable low");

endmodule // cic_core_interrupt_control
`default_nettype wire

// [bench/cic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_core_model
    import cic_pkg::*;
(
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    int hangs = 0;
    initial
    begin
        hsel = 1'b1;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = CIC_HSIZE_WORD;
        hwdata = 32'h00000000;
    end
    // =========================================================
    // Core access: one word, waits on hready
    task automatic xfer(input logic [31:0] a, input logic wr,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        haddr <= a;
        htrans <= CIC_HTRANS_NONSEQ;
        hwrite <= wr;
        hwdata <= ~hwdata;
        @(posedge mclk);
        while (hready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge mclk);
        end
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        @(posedge mclk);
        while (hready !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge mclk);
        end
        rd = hrdata;
        if (n >= 50) hangs++;
    endtask
endmodule // cic_core_model
`default_nettype wire

// [bench/tb_core_interrupt_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_core_interrupt_control
    import cic_pkg::*;
;
    logic mclk, rst, ce, timerOverflow, periphPending;
    logic hsel, hwrite, hreadyout, hresp, coreIrqReq, sysIrq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors = 0;
    int testsRun = 0;
    localparam logic [31:0] aCtrl = {20'h0, CIC_IDX_CTRL, 2'h0};
    localparam logic [31:0] aMirr = {20'h0, CIC_IDX_CTRL_MIRROR, 2'h0};
    localparam logic [31:0] aStat = {20'h0, CIC_IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] aClr = {20'h0, CIC_IDX_IRQ_CLEAR, 2'h0};
    localparam logic [31:0] aEn = {20'h0, CIC_IDX_IRQ_ENABLE, 2'h0};

    cic_core_interrupt_control dut (.mclk(mclk), .rst(rst), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timerOverflow(timerOverflow), .periphPending(periphPending),
        .coreIrqReq(coreIrqReq), .sysIrq(sysIrq));
    cic_core_model core (.mclk(mclk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // =========================================================
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        testsRun++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        core.xfer(a, 1'b1, d, rd);
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        core.xfer(a, 1'b0, 32'h00000000, rd);
        chk(rd, exp, "read");
        chk({31'h0, hresp}, {31'h0, CIC_HRESP_OKAY}, "resp");
    endtask
    task automatic irqChk(input logic req, input logic sys);
        repeat (3) @(posedge mclk);
        chk({31'h0, coreIrqReq}, {31'h0, req}, "core request");
        chk({31'h0, sysIrq}, {31'h0, sys}, "event irq");
    endtask
    task automatic pulse();
        @(posedge mclk);
        timerOverflow <= 1'b1;
        @(posedge mclk);
        timerOverflow <= 1'b0;
    endtask
    // =========================================================
    // Scenarios
    task automatic tReset();
        rdChk(aCtrl, 32'h00000000);
        rdChk(aStat, 32'h00000000);
        irqChk(1'b0, 1'b0);
        $display("done reset");
    endtask
    task automatic tRegs();
        wr(aCtrl, 32'h000000e4);
        rdChk(aCtrl, 32'h000000e4);
        rdChk(aMirr, 32'h000000e4);
        wr(aMirr, 32'h00000040);
        rdChk(aCtrl, 32'h00000040);
        wr(32'h00000100, 32'h000000ff);
        rdChk(32'h00000100, 32'h00000000);
        rdChk(aCtrl, 32'h00000040);
        wr(aCtrl, 32'h00000000);
        $display("done regs");
    endtask
    task automatic tTimer();
        pulse();
        rdChk(aCtrl, 32'h00000004);
        wr(aCtrl, 32'h00000064);
        irqChk(1'b0, 1'b0);
        wr(aCtrl, 32'h000000e4);
        irqChk(1'b1, 1'b0);
        wr(aCtrl, 32'h000000c4);
        irqChk(1'b0, 1'b0);
        repeat (20) @(posedge mclk);
        rdChk(aCtrl, 32'h000000c4);
        wr(aCtrl, 32'h00000000);
        rdChk(aCtrl, 32'h00000000);
        pulse();
        wr(aCtrl, 32'h00000000);
        wr(aCtrl, 32'h000000a0);
        irqChk(1'b0, 1'b0);
        pulse();
        irqChk(1'b1, 1'b0);
        wr(aCtrl, 32'h00000000);
        $display("done timer");
    endtask
    task automatic tPeriph();
        periphPending <= 1'b1;
        wr(aCtrl, 32'h00000040);
        irqChk(1'b0, 1'b0);
        wr(aCtrl, 32'h000000c0);
        irqChk(1'b1, 1'b0);
        wr(aCtrl, 32'h00000080);
        irqChk(1'b0, 1'b0);
        periphPending <= 1'b0;
        wr(aCtrl, 32'h000000c0);
        irqChk(1'b0, 1'b0);
        wr(aCtrl, 32'h00000000);
        $display("done periph");
    endtask
    task automatic tEvents();
        wr(aClr, 32'h00000003);
        wr(aEn, 32'h00000001);
        rdChk(aEn, 32'h00000001);
        pulse();
        irqChk(1'b0, 1'b1);
        rdChk(aStat, 32'h00000001);
        wr(aEn, 32'h00000000);
        irqChk(1'b0, 1'b0);
        wr(aClr, 32'h00000001);
        rdChk(aStat, 32'h00000000);
        rdChk(aClr, 32'h00000000);
        wr(aEn, 32'h00000003);
        periphPending <= 1'b1;
        wr(aCtrl, 32'h00000040);
        irqChk(1'b0, 1'b1);
        rdChk(aStat, 32'h00000002);
        wr(aClr, 32'h00000002);
        irqChk(1'b0, 1'b0);
        periphPending <= 1'b0;
        wr(aCtrl, 32'h00000000);
        $display("done events");
    endtask
    task automatic tFreeze();
        wr(aCtrl, 32'h000000a0);
        ce <= 1'b0;
        pulse();
        ce <= 1'b1;
        irqChk(1'b0, 1'b0);
        rdChk(aCtrl, 32'h000000a0);
        rdChk(aStat, 32'h00000000);
        pulse();
        irqChk(1'b1, 1'b1);
        rst <= 1'b1;
        @(posedge mclk);
        chk({30'h0, coreIrqReq, sysIrq}, 32'h00000000, "reset irq");
        rst <= 1'b0;
        rdChk(aCtrl, 32'h00000000);
        rdChk(aEn, 32'h00000000);
        irqChk(1'b0, 1'b0);
        $display("done freeze");
    endtask
    // =========================================================
    // Verdict
    task automatic print_verdict();
        errors += core.hangs;
        $display("Checks %0d, mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        print_verdict();
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        timerOverflow = 1'b0;
        periphPending = 1'b0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        tReset();
        tRegs();
        tTimer();
        tPeriph();
        tEvents();
        tFreeze();
        print_verdict();
    end
endmodule // tb_core_interrupt_control
`default_nettype wire
